//--- common/abs_consts.svh
// Purpose: timing constants shared by both ends of the address arbitration link
// Assumes: one 200 MHz bus clock, active-low bus lines
// Notes: definitions only
`ifndef ABS_CONSTS_SVH
`define ABS_CONSTS_SVH
`define ABS_ASSERTED 1'b0
`define ABS_NEGATED 1'b1
`define ABS_BR_GAP_CYCLES 2'h1
`define ABS_START_CYCLES 2'h1
`define ABS_PARK_DEFAULT 1'b0
`endif

//--- common/abs_pkg.sv
// Purpose: types for the address arbitration and transfer start block
// Assumes: consts header holds the numbers
// Notes: state codes change one bit per step from idle through start or ds tenure to wait-ack
package abs_pkg;
    typedef enum logic [2:0] {
        ABS_IDLE = 3'h0,
        ABS_START = 3'h1,
        ABS_WAIT_ACK = 3'h3,
        ABS_DS_TENURE = 3'h2,
        ABS_RELEASE = 3'h6
    } abs_state_t;
    typedef enum logic [1:0] {
        ABS_ARB_IDLE = 2'h0,
        ABS_ARB_GRANT = 2'h1,
        ABS_ARB_BUSY = 2'h3
    } abs_arb_state_t;
endpackage

//--- common/abs_bus_if.sv
// Purpose: shared address arbitration wires between processor end and arbiter end
// Assumes: the testbench resolves wired lines from the enables
// Notes: lines are active low; a line nobody drives floats high
`timescale 1ns/1ps
interface abs_bus_if;
    logic bus_request_n;
    logic bus_grant_n;
    logic addr_owner_busy_n_o;
    logic addr_owner_busy_n_oe;
    logic addr_owner_busy_n_i;
    logic mem_transfer_start_n_o;
    logic mem_transfer_start_n_oe;
    logic mem_transfer_start_n_i;
    logic direct_store_start_n_o;
    logic direct_store_start_n_oe;
    logic direct_store_start_n_i;
    logic address_retry_n;
    logic address_acknowledge_n;
    modport dev (
        output bus_request_n,
        input bus_grant_n,
        output addr_owner_busy_n_o,
        output addr_owner_busy_n_oe,
        input addr_owner_busy_n_i,
        output mem_transfer_start_n_o,
        output mem_transfer_start_n_oe,
        input mem_transfer_start_n_i,
        output direct_store_start_n_o,
        output direct_store_start_n_oe,
        input direct_store_start_n_i,
        input address_retry_n,
        input address_acknowledge_n
    );
    modport arb (
        input bus_request_n,
        output bus_grant_n,
        input addr_owner_busy_n_i,
        input mem_transfer_start_n_i,
        input direct_store_start_n_i,
        output address_retry_n,
        output address_acknowledge_n
    );
endinterface

//--- rtl/abs_proc_end.sv
// Purpose: processor end of address bus arbitration and transfer start
// Assumes: bus lines come from other chips and pass a three-stage sampler
// Notes: tristate timing inside a cycle is below this model's resolution
`timescale 1ns/1ps
`include "abs_consts.svh"
module abs_proc_end (
    input wire logic clk,
    input wire logic rst,
    abs_bus_if.dev bus,
    input wire logic xfer_pending,
    input wire logic xfer_direct_store,
    input wire logic xfer_cancel,
    input wire logic park_enable,
    input wire logic retry_push_self,
    output logic xfer_started,
    output logic tenure_done,
    output logic snoop_valid,
    output logic data_bus_request
);
    // ----------------------------------------
    // input sampling
    // ----------------------------------------
    // three stages per pin; the third stage is taken as is, with no agreement check
    logic [2:0] bg_s_q, abb_s_q, ts_s_q, xts_s_q, rty_s_q, ack_s_q;
    logic bg_f_q, abb_f_q, ts_f_q, xts_f_q, rty_f_q, ack_f_q;
    logic bg_f_d, abb_f_d, ts_f_d, xts_f_d, rty_f_d, ack_f_d;

    // one-cycle strobes (start, acknowledge) must pass, so the last stage is taken as is
    function automatic logic filt(input logic [2:0] s);
        filt = s[2];
    endfunction

    // sampler registers, reset to negated
    always_ff @(posedge clk) begin
        if (rst) begin
            bg_s_q <= 3'h7;
            abb_s_q <= 3'h7;
            ts_s_q <= 3'h7;
            xts_s_q <= 3'h7;
            rty_s_q <= 3'h7;
            ack_s_q <= 3'h7;
            bg_f_q <= `ABS_NEGATED;
            abb_f_q <= `ABS_NEGATED;
            ts_f_q <= `ABS_NEGATED;
            xts_f_q <= `ABS_NEGATED;
            rty_f_q <= `ABS_NEGATED;
            ack_f_q <= `ABS_NEGATED;
        end else begin
            bg_s_q <= {bg_s_q[1:0], bus.bus_grant_n};
            abb_s_q <= {abb_s_q[1:0], bus.addr_owner_busy_n_i};
            ts_s_q <= {ts_s_q[1:0], bus.mem_transfer_start_n_i};
            xts_s_q <= {xts_s_q[1:0], bus.direct_store_start_n_i};
            rty_s_q <= {rty_s_q[1:0], bus.address_retry_n};
            ack_s_q <= {ack_s_q[1:0], bus.address_acknowledge_n};
            bg_f_q <= bg_f_d;
            abb_f_q <= abb_f_d;
            ts_f_q <= ts_f_d;
            xts_f_q <= xts_f_d;
            rty_f_q <= rty_f_d;
            ack_f_q <= ack_f_d;
        end
    end

    // filtered levels
    always_comb begin
        bg_f_d = filt(bg_s_q);
        abb_f_d = filt(abb_s_q);
        ts_f_d = filt(ts_s_q);
        xts_f_d = filt(xts_s_q);
        rty_f_d = filt(rty_s_q);
        ack_f_d = filt(ack_s_q);
    end

    // ----------------------------------------
    // arbitration and tenure
    // ----------------------------------------
    abs_pkg::abs_state_t st_q, st_d;
    logic br_q, br_d;
    logic rty_prev_q, rty_prev_d;
    logic gap_q, gap_d;
    logic win_q, win_d;
    logic qual_prev_q, qual_prev_d;
    logic abb_q, abb_d, abb_oe_q, abb_oe_d;
    logic ts_q, ts_d, ts_oe_q, ts_oe_d;
    logic xs_q, xs_d, xs_oe_q, xs_oe_d;
    logic started_q, started_d, done_q, done_d, snoop_q, snoop_d, dreq_q, dreq_d;
    logic rty_now, ack_now, qual, take, want;

    // next-state logic for the whole tenure
    always_comb begin
        rty_now = (rty_f_q == `ABS_ASSERTED);
        ack_now = (ack_f_q == `ABS_ASSERTED);
        want = xfer_pending && !xfer_cancel; // cancel drops a pending request
        // qualified: grant on, no busy, no retry now or last cycle
        qual = (bg_f_q == `ABS_ASSERTED) && (abb_f_q == `ABS_NEGATED)
            && !rty_now && !rty_prev_q && !win_q; // foreign tenure window blocks too
        st_d = st_q;
        abb_d = abb_q;
        abb_oe_d = abb_oe_q;
        ts_d = `ABS_NEGATED;
        ts_oe_d = 1'b0;
        xs_d = `ABS_NEGATED;
        xs_oe_d = 1'b0;
        started_d = 1'b0;
        done_d = 1'b0;
        dreq_d = 1'b0;
        gap_d = 1'b0;
        // start line: negated for one cycle after its pulse, then float
        if (ts_q == `ABS_ASSERTED) begin
            ts_oe_d = 1'b1;
        end
        if (xs_q == `ABS_ASSERTED) begin
            xs_oe_d = 1'b1;
        end
        // grant seen qualified last cycle still counts as it negates
        take = (st_q == abs_pkg::ABS_IDLE) && want && (qual || (qual_prev_q && abb_f_q == `ABS_NEGATED));
        case (st_q)
            abs_pkg::ABS_IDLE: begin
                if (take) begin
                    abb_d = `ABS_ASSERTED;
                    abb_oe_d = 1'b1;
                    started_d = 1'b1;
                    gap_d = 1'b1;
                    if (xfer_direct_store) begin
                        xs_d = `ABS_ASSERTED; // memory start stays negated
                        xs_oe_d = 1'b1;
                        st_d = abs_pkg::ABS_DS_TENURE;
                    end else begin
                        ts_d = `ABS_ASSERTED; // one cycle with busy
                        ts_oe_d = 1'b1;
                        dreq_d = 1'b1;
                        st_d = abs_pkg::ABS_START;
                    end
                end
            end
            abs_pkg::ABS_START, abs_pkg::ABS_DS_TENURE, abs_pkg::ABS_WAIT_ACK: begin
                // grant ignored while owning
                if (ack_now) begin
                    abb_d = `ABS_NEGATED;
                    done_d = 1'b1;
                    st_d = abs_pkg::ABS_RELEASE;
                end else begin
                    st_d = abs_pkg::ABS_WAIT_ACK;
                end
            end
            abs_pkg::ABS_RELEASE: begin
                // float busy at end of the negated cycle
                abb_oe_d = 1'b0;
                st_d = abs_pkg::ABS_IDLE;
            end
            default: begin
                st_d = abs_pkg::ABS_IDLE;
                abb_d = `ABS_NEGATED;
                abb_oe_d = 1'b0;
            end
        endcase
        // request: work pending, no qualified grant, not parked, no gap
        br_d = !(want && st_q == abs_pkg::ABS_IDLE && !take && !gap_q && !(park_enable && qual)
            && (!rty_now || retry_push_self));
        rty_prev_d = rty_now;
        qual_prev_d = qual;
        // foreign start opens a window closed the cycle after acknowledge
        snoop_d = (st_q == abs_pkg::ABS_IDLE) && (ts_f_q == `ABS_ASSERTED);
        // own tenures are covered by the state; only a foreign start opens the window
        if (ack_now) begin
            win_d = 1'b0;
        end else if (st_q == abs_pkg::ABS_IDLE && (ts_f_q == `ABS_ASSERTED || xts_f_q == `ABS_ASSERTED)) begin
            win_d = 1'b1;
        end else begin
            win_d = win_q;
        end
    end

    // register everything, reset negates and floats
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= abs_pkg::ABS_IDLE;
            br_q <= `ABS_NEGATED;
            rty_prev_q <= 1'b0;
            gap_q <= 1'b0;
            win_q <= 1'b0;
            qual_prev_q <= 1'b0;
            abb_q <= `ABS_NEGATED;
            abb_oe_q <= 1'b0;
            ts_q <= `ABS_NEGATED;
            ts_oe_q <= 1'b0;
            xs_q <= `ABS_NEGATED;
            xs_oe_q <= 1'b0;
            started_q <= 1'b0;
            done_q <= 1'b0;
            snoop_q <= 1'b0;
            dreq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            br_q <= br_d;
            rty_prev_q <= rty_prev_d;
            gap_q <= gap_d;
            win_q <= win_d;
            qual_prev_q <= qual_prev_d;
            abb_q <= abb_d;
            abb_oe_q <= abb_oe_d;
            ts_q <= ts_d;
            ts_oe_q <= ts_oe_d;
            xs_q <= xs_d;
            xs_oe_q <= xs_oe_d;
            started_q <= started_d;
            done_q <= done_d;
            snoop_q <= snoop_d;
            dreq_q <= dreq_d;
        end
    end

    // outputs straight from flops
    assign bus.bus_request_n = br_q;
    assign bus.addr_owner_busy_n_o = abb_q;
    assign bus.addr_owner_busy_n_oe = abb_oe_q;
    assign bus.mem_transfer_start_n_o = ts_q;
    assign bus.mem_transfer_start_n_oe = ts_oe_q;
    assign bus.direct_store_start_n_o = xs_q;
    assign bus.direct_store_start_n_oe = xs_oe_q;
    assign xfer_started = started_q;
    assign tenure_done = done_q;
    assign snoop_valid = snoop_q;
    assign data_bus_request = dreq_q;
endmodule

//--- rtl/abs_arb_end.sv
// Purpose: arbiter end: grants the address bus and acknowledges tenures
// Assumes: single requesting processor, lines sampled through three stages
// Notes: parks the bus on the processor when park_on is high
`timescale 1ns/1ps
`include "abs_consts.svh"
module abs_arb_end (
    input wire logic clk,
    input wire logic rst,
    abs_bus_if.arb bus,
    input wire logic park_on,
    input wire logic retry_req,
    input wire logic ack_hold,
    output logic tenure_seen
);
    // ----------------------------------------
    // sampling and grant control
    // ----------------------------------------
    logic [2:0] br_s_q, ts_s_q, xs_s_q;
    logic br_f_q, ts_f_q, xs_f_q, br_f_d, ts_f_d, xs_f_d;
    abs_pkg::abs_arb_state_t st_q, st_d;
    logic bg_q, bg_d, ack_q, ack_d, rty_q, rty_d, seen_q, seen_d;
    logic start_now;

    // one-cycle strobes must pass, so the last stage is taken as is
    function automatic logic filt(input logic [2:0] s);
        filt = s[2];
    endfunction

    // grant may move any cycle; start is acknowledged once ack_hold drops
    always_comb begin
        br_f_d = filt(br_s_q);
        ts_f_d = filt(ts_s_q);
        xs_f_d = filt(xs_s_q);
        start_now = (ts_f_q == `ABS_ASSERTED) || (xs_f_q == `ABS_ASSERTED);
        st_d = st_q;
        bg_d = `ABS_NEGATED;
        ack_d = `ABS_NEGATED;
        rty_d = retry_req ? `ABS_ASSERTED : `ABS_NEGATED;
        seen_d = 1'b0;
        case (st_q)
            abs_pkg::ABS_ARB_IDLE: begin
                // a start without our grant is a foreign tenure; it still needs its acknowledge
                if (start_now) begin
                    st_d = abs_pkg::ABS_ARB_BUSY;
                end else if (br_f_q == `ABS_ASSERTED || park_on) begin
                    bg_d = `ABS_ASSERTED;
                    st_d = abs_pkg::ABS_ARB_GRANT;
                end
            end
            abs_pkg::ABS_ARB_GRANT: begin
                bg_d = `ABS_ASSERTED;
                if (start_now) begin
                    bg_d = `ABS_NEGATED;
                    st_d = abs_pkg::ABS_ARB_BUSY;
                end else if (br_f_q == `ABS_NEGATED && !park_on) begin
                    bg_d = `ABS_NEGATED;
                    st_d = abs_pkg::ABS_ARB_IDLE;
                end
            end
            abs_pkg::ABS_ARB_BUSY: begin
                if (!ack_hold) begin
                    ack_d = `ABS_ASSERTED; // one-cycle acknowledge
                    seen_d = 1'b1;
                    st_d = abs_pkg::ABS_ARB_IDLE;
                end
            end
            default: begin
                st_d = abs_pkg::ABS_ARB_IDLE;
            end
        endcase
    end

    // registers; reset negates all outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            br_s_q <= 3'h7;
            ts_s_q <= 3'h7;
            xs_s_q <= 3'h7;
            br_f_q <= `ABS_NEGATED;
            ts_f_q <= `ABS_NEGATED;
            xs_f_q <= `ABS_NEGATED;
            st_q <= abs_pkg::ABS_ARB_IDLE;
            bg_q <= `ABS_NEGATED;
            ack_q <= `ABS_NEGATED;
            rty_q <= `ABS_NEGATED;
            seen_q <= 1'b0;
        end else begin
            br_s_q <= {br_s_q[1:0], bus.bus_request_n};
            ts_s_q <= {ts_s_q[1:0], bus.mem_transfer_start_n_i};
            xs_s_q <= {xs_s_q[1:0], bus.direct_store_start_n_i};
            br_f_q <= br_f_d;
            ts_f_q <= ts_f_d;
            xs_f_q <= xs_f_d;
            st_q <= st_d;
            bg_q <= bg_d;
            ack_q <= ack_d;
            rty_q <= rty_d;
            seen_q <= seen_d;
        end
    end

    assign bus.bus_grant_n = bg_q;
    assign bus.address_acknowledge_n = ack_q;
    assign bus.address_retry_n = rty_q;
    assign tenure_seen = seen_q;
endmodule

//--- test/abs_link_sva.sv
// Purpose: concurrent checks on the wires between the two ends
// Assumes: resolved wires plus the processor's own drive and enable
// Notes: windows allow for the three-stage input samplers, except the two retry checks, which span only four cycles
`timescale 1ns/1ps
module abs_link_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_request_n,
    input wire logic address_retry_n,
    input wire logic address_acknowledge_n,
    input wire logic addr_owner_busy_n_o,
    input wire logic addr_owner_busy_n_oe,
    input wire logic addr_owner_busy_n_i,
    input wire logic mem_transfer_start_n_o,
    input wire logic mem_transfer_start_n_oe,
    input wire logic direct_store_start_n_o,
    input wire logic direct_store_start_n_oe
);
    logic ts_on, xs_on, abb_on;
    // -------------------------------------------
    // asserted means driven and low
    // -------------------------------------------
    assign ts_on = mem_transfer_start_n_oe && !mem_transfer_start_n_o;
    assign xs_on = direct_store_start_n_oe && !direct_store_start_n_o;
    assign abb_on = addr_owner_busy_n_oe && !addr_owner_busy_n_o;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // reset itself is checked, so this one is never disabled
    chk_reset_negates: assert property (disable iff (1'b0) rst |=> bus_request_n && !addr_owner_busy_n_oe
        && !mem_transfer_start_n_oe && !direct_store_start_n_oe) else $error("outputs live after reset");
    chk_start_with_busy: assert property (ts_on |-> abb_on) else $error("start without busy");
    chk_start_one_cycle: assert property (ts_on |=> (mem_transfer_start_n_oe && mem_transfer_start_n_o)
        ##1 !mem_transfer_start_n_oe) else $error("start shape wrong");
    chk_ds_no_mem: assert property (xs_on |-> (!ts_on)[*6]) else $error("memory start in ds tenure");
    chk_busy_opens: assert property ($rose(abb_on) |-> ts_on || xs_on) else $error("busy without start");
    chk_busy_release: assert property (abb_on && !address_acknowledge_n |-> ##[1:6]
        (addr_owner_busy_n_oe && addr_owner_busy_n_o)) else $error("busy held after ack");
    chk_busy_floats: assert property (addr_owner_busy_n_oe && addr_owner_busy_n_o |=>
        !addr_owner_busy_n_oe) else $error("busy not floated");
    chk_req_drop: assert property ($rose(abb_on) |-> ##[0:1] bus_request_n) else $error("request kept");
    chk_one_tenure: assert property (ts_on |=> (!ts_on && !xs_on)[*6]) else $error("second start");
    chk_take_free: assert property ($rose(abb_on) |-> $past(addr_owner_busy_n_i)) else $error("took busy bus");
    chk_retry_block: assert property ((!address_retry_n)[*4] |-> !$rose(abb_on)) else $error("took in retry");
    chk_retry_req: assert property ($fell(address_retry_n) |-> ##[1:4] bus_request_n)
        else $error("request kept after retry");
endmodule

//--- test/address_bus_arbitration_start_test.sv
// Purpose: drives both ends of the arbitration link through their user ports
// Assumes: a line nobody drives floats high; a foreign master only pulls low
// Notes: waits are bounded; the samplers add about four cycles each way
`timescale 1ns/1ps
module address_bus_arbitration_start_test;
    logic clk, rst, pend, ds, cancel, park, push, park_on, retry_req, ack_hold, f_abb, f_ts;
    logic started, done, snoop, dreq, seen;
    int errors = 0;
    int n_checks = 0;
    abs_bus_if abs_bus_if_inst ();
    // -------------------------------------------
    // wire resolution
    // -------------------------------------------
    assign abs_bus_if_inst.addr_owner_busy_n_i = abs_bus_if_inst.addr_owner_busy_n_oe ?
        abs_bus_if_inst.addr_owner_busy_n_o : !f_abb;
    assign abs_bus_if_inst.mem_transfer_start_n_i = abs_bus_if_inst.mem_transfer_start_n_oe ?
        abs_bus_if_inst.mem_transfer_start_n_o : !f_ts;
    assign abs_bus_if_inst.direct_store_start_n_i = abs_bus_if_inst.direct_store_start_n_oe ?
        abs_bus_if_inst.direct_store_start_n_o : 1'b1;
    abs_proc_end abs_proc_end_inst (.clk(clk), .rst(rst), .bus(abs_bus_if_inst.dev), .xfer_pending(pend),
        .xfer_direct_store(ds), .xfer_cancel(cancel), .park_enable(park), .retry_push_self(push),
        .xfer_started(started), .tenure_done(done), .snoop_valid(snoop), .data_bus_request(dreq));
    abs_arb_end abs_arb_end_inst (.clk(clk), .rst(rst), .bus(abs_bus_if_inst.arb), .park_on(park_on),
        .retry_req(retry_req), .ack_hold(ack_hold), .tenure_seen(seen));
    abs_link_sva abs_link_sva_inst (.clk(clk), .rst(rst), .bus_request_n(abs_bus_if_inst.bus_request_n),
        .address_retry_n(abs_bus_if_inst.address_retry_n),
        .address_acknowledge_n(abs_bus_if_inst.address_acknowledge_n),
        .addr_owner_busy_n_o(abs_bus_if_inst.addr_owner_busy_n_o),
        .addr_owner_busy_n_oe(abs_bus_if_inst.addr_owner_busy_n_oe),
        .addr_owner_busy_n_i(abs_bus_if_inst.addr_owner_busy_n_i),
        .mem_transfer_start_n_o(abs_bus_if_inst.mem_transfer_start_n_o),
        .mem_transfer_start_n_oe(abs_bus_if_inst.mem_transfer_start_n_oe),
        .direct_store_start_n_o(abs_bus_if_inst.direct_store_start_n_o),
        .direct_store_start_n_oe(abs_bus_if_inst.direct_store_start_n_oe));
    // -------------------------------------------
    // helpers
    // -------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // cycles until the chosen pulse shows, lim if it never does
    task automatic wait_for(input int sel, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (n < lim && !(sel == 0 ? started === 1'b1 : sel == 1 ? done === 1'b1 : snoop === 1'b1));
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one whole tenure; the wire pattern at start tells memory from ds
    task automatic run_xfer(input logic is_ds);
        int n;
        @(posedge clk);
        ds <= is_ds;
        pend <= 1'b1;
        wait_for(0, 40, n);
        chk(8'(n < 40), 8'h01);
        chk({5'h0, abs_bus_if_inst.addr_owner_busy_n_i, abs_bus_if_inst.mem_transfer_start_n_i, abs_bus_if_inst.direct_store_start_n_i}, is_ds ? 8'h02 : 8'h01);
        chk({7'h0, dreq}, {7'h0, !is_ds});
        @(posedge clk);
        pend <= 1'b0;
        wait_for(1, 40, n);
        chk(8'(n < 40), 8'h01);
    endtask
    // -------------------------------------------
    // scenarios
    // -------------------------------------------
    task automatic t_basic();
        chk({5'h0, abs_bus_if_inst.bus_request_n, abs_bus_if_inst.addr_owner_busy_n_i, abs_bus_if_inst.mem_transfer_start_n_i}, 8'h07);
        run_xfer(1'b0);
        run_xfer(1'b0);
        run_xfer(1'b1);
        $display("test basic done");
    endtask
    task automatic t_cancel();
        int n;
        @(posedge clk);
        cancel <= 1'b1;
        pend <= 1'b1;
        wait_for(0, 30, n);
        chk(8'(n), 8'd30);
        @(posedge clk);
        cancel <= 1'b0;
        pend <= 1'b0;
        $display("test cancel done");
    endtask
    // a held block (retry or foreign busy) must keep the processor off
    task automatic t_block(input logic use_retry);
        int n;
        @(posedge clk);
        retry_req <= use_retry;
        f_abb <= !use_retry;
        repeat (6) @(posedge clk);
        pend <= 1'b1;
        wait_for(0, 20, n);
        chk(8'(n), 8'd20);
        if (use_retry)
            chk({7'h0, abs_bus_if_inst.bus_request_n}, 8'h01);
        @(posedge clk);
        retry_req <= 1'b0;
        f_abb <= 1'b0;
        run_xfer(1'b0);
        $display("test block done");
    endtask
    task automatic t_snoop_park();
        int n;
        @(posedge clk);
        f_ts <= 1'b1;
        @(posedge clk);
        f_ts <= 1'b0;
        wait_for(2, 10, n);
        chk(8'(n < 10), 8'h01);
        repeat (15) @(posedge clk);
        park <= 1'b1;
        park_on <= 1'b1;
        run_xfer(1'b0);
        park <= 1'b0;
        park_on <= 1'b0;
        $display("test snoop park done");
    endtask
    task automatic t_slow_ack();
        int n;
        @(posedge clk);
        ack_hold <= 1'b1;
        pend <= 1'b1;
        wait_for(0, 40, n);
        @(posedge clk);
        pend <= 1'b0;
        wait_for(1, 15, n);
        chk({7'h0, abs_bus_if_inst.addr_owner_busy_n_i}, 8'h00);
        @(posedge clk);
        ack_hold <= 1'b0;
        wait_for(1, 20, n);
        chk(8'(n < 20), 8'h01);
        $display("test slow ack done");
    endtask
    // -------------------------------------------
    // clock, reset, sequence, watchdog
    // -------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    initial begin
        {rst, pend, ds, cancel, park, push, park_on, retry_req, ack_hold, f_abb, f_ts} = 11'h400;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        t_basic();
        t_cancel();
        t_block(1'b1);
        t_block(1'b0);
        t_snoop_park();
        t_slow_ack();
        give_verdict();
    end
    // the tests take well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule
